/* verilog/dpsm_host.sv */
// Host controller for one port of an asynchronous dual-port SRAM.
// Assumes the memory port pins are wired directly; inputs synchronous.
`timescale 1ns/1ps
`default_nettype none
module dpsm_host
	import dpsm_pkg::*;
#(
	parameter bit IS_LEFT = 1'b1,
	parameter bit DEPTH_64K = 1'b0
) (
	input wire logic clk_sys,
	input wire logic resetn,
	// User request side
	input wire logic req_valid,
	output logic req_ready,
	input wire dpsm_cmd_t req_cmd,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_lanes,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic rsp_busy_hit,
	output logic mbox_pending,
	// Memory port pins
	output logic [ADDR_W-1:0] mem_addr,
	output logic chip_en_n,
	output logic rw_n,
	output logic out_en_n,
	output logic upper_lane_en_n,
	output logic lower_lane_en_n,
	output logic flag_space_sel_n,
	input wire logic [DATA_W-1:0] mem_data_i,
	output logic [DATA_W-1:0] mem_data_o,
	output logic [1:0] mem_data_oe,
	input wire logic busy_n,
	input wire logic int_n
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int HALF = DATA_W / 2;
	dpsm_state_t state_r;
	logic [3:0] cnt_r;
	dpsm_cmd_t cmd_r;
	logic is_wr;
	logic is_sem;
	logic [1:0] lanes_r;
	logic busy_seen_r;
	logic [DATA_W-1:0] wdata_sel;
	logic [ADDR_W-1:0] amask;
	logic [ADDR_W-1:0] mbox_own;
	logic [ADDR_W-1:0] mbox_peer;
	logic load_w;
	logic wr_phase;

	assign amask = DEPTH_64K ? ADDR_MASK_64K : ADDR_MASK_32K;
	assign mbox_own = DEPTH_64K ? MBOX_OWN_64K : MBOX_OWN_32K;
	assign mbox_peer = DEPTH_64K ? MBOX_PEER_64K : MBOX_PEER_32K;

	// Left owns reading 7FFE, writes 7FFF (FFFE, FFFF with DEPTH_64K); right is mirrored
	// set target is the peer's location
	function automatic logic [ADDR_W-1:0] mbox_addr(input dpsm_cmd_t c,
			input logic [ADDR_W-1:0] own, input logic [ADDR_W-1:0] peer);
		logic [ADDR_W-1:0] set_a;
		logic [ADDR_W-1:0] clr_a;
		set_a = IS_LEFT ? own : peer;
		clr_a = IS_LEFT ? peer : own;
		mbox_addr = (c == DPSM_CMD_MBOX_SET) ? set_a : clr_a;
	endfunction

	assign is_wr = (cmd_r == DPSM_CMD_RAM_WR) || (cmd_r == DPSM_CMD_SEM_WR)
		|| (cmd_r == DPSM_CMD_MBOX_SET);
	assign is_sem = (cmd_r == DPSM_CMD_SEM_RD) || (cmd_r == DPSM_CMD_SEM_WR);
	assign req_ready = (state_r == DPSM_IDLE);
	assign load_w = req_valid && req_ready;
	// Data stands for the whole strobe; a bus released early would
	// let the memory latch a floating value at the strobe's end
	assign wr_phase = is_wr && (state_r == DPSM_SETUP ||
		(state_r == DPSM_STROBE && cnt_r > 4'h1));

	// flag write carries only bit 0, replicated harmlessly
	assign wdata_sel = (req_cmd == DPSM_CMD_SEM_WR) ?
		{DATA_W{req_wdata[0]}} : req_wdata;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Setup phase holds address before strobe; strobe holds for access
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_r <= DPSM_IDLE;
			cnt_r <= 4'h0;
		end else begin
			case (state_r)
				DPSM_IDLE: begin
					if (load_w) begin
						state_r <= DPSM_SETUP;
						cnt_r <= SETUP_CNT;
					end
				end
				DPSM_SETUP: begin
					if (cnt_r <= 4'h1) begin
						state_r <= DPSM_STROBE;
						cnt_r <= ACCESS_CNT;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				DPSM_STROBE: begin
					if (cnt_r <= 4'h1)
						state_r <= DPSM_DONE;
					else
						cnt_r <= cnt_r - 4'h1;
				end
				default: begin
					state_r <= DPSM_IDLE;
				end
			endcase
		end
	end

	// Captured request
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cmd_r <= DPSM_CMD_RAM_RD;
			lanes_r <= 2'h0;
			mem_addr <= '0;
		end else if (load_w) begin
			cmd_r <= req_cmd;
			// lane choice for RAM reads and writes
			lanes_r <= req_lanes;
			if (req_cmd == DPSM_CMD_MBOX_SET || req_cmd == DPSM_CMD_MBOX_CLR)
				mem_addr <= mbox_addr(req_cmd, mbox_own, mbox_peer);
			else
				mem_addr <= req_addr & amask;
		end
	end

	// ----------------------------------------
	// Control pins
	// ----------------------------------------
	// all strobes idle high between accesses: port deselected
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			chip_en_n <= 1'b1;
			rw_n <= 1'b1;
			out_en_n <= 1'b1;
			upper_lane_en_n <= 1'b1;
			lower_lane_en_n <= 1'b1;
			flag_space_sel_n <= 1'b1;
		end else if (state_r == DPSM_SETUP && is_sem) begin
			// flag access: chip enable and lanes kept off
			// flag read keeps write strobe high, output enable low
			chip_en_n <= 1'b1;
			upper_lane_en_n <= 1'b1;
			lower_lane_en_n <= 1'b1;
			flag_space_sel_n <= 1'b0;
			rw_n <= !is_wr;
			out_en_n <= is_wr;
		end else if (state_r == DPSM_SETUP) begin
			// mailbox uses both lanes, RAM uses request
			chip_en_n <= 1'b0;
			flag_space_sel_n <= 1'b1;
			upper_lane_en_n <= is_cmd_mbox() ? 1'b0 : !lanes_r[1];
			lower_lane_en_n <= is_cmd_mbox() ? 1'b0 : !lanes_r[0];
			rw_n <= !is_wr;
			out_en_n <= is_wr;
		end else if (state_r == DPSM_STROBE && cnt_r <= 4'h1) begin
			// All strobes rise on this edge, the same edge the data lanes release
			chip_en_n <= 1'b1;
			rw_n <= 1'b1;
			out_en_n <= 1'b1;
			upper_lane_en_n <= 1'b1;
			lower_lane_en_n <= 1'b1;
			flag_space_sel_n <= 1'b1;
		end
	end

	function automatic logic is_cmd_mbox();
		is_cmd_mbox = (cmd_r == DPSM_CMD_MBOX_SET) ||
			(cmd_r == DPSM_CMD_MBOX_CLR);
	endfunction

	// ----------------------------------------
	// Data lanes
	// ----------------------------------------
	// drive only enabled lanes (both lanes for flag writes), never during reads
	dpsm_lane #(.W(HALF)) u_lane_lo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.load(load_w),
		.drive(wr_phase && (is_sem || is_cmd_mbox() || lanes_r[0])),
		.din(wdata_sel[HALF-1:0]),
		.dout(mem_data_o[HALF-1:0]),
		.oe(mem_data_oe[0])
	);
	dpsm_lane #(.W(DATA_W-HALF)) u_lane_hi (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.load(load_w),
		.drive(wr_phase && (is_sem || is_cmd_mbox() || lanes_r[1])),
		.din(wdata_sel[DATA_W-1:HALF]),
		.dout(mem_data_o[DATA_W-1:HALF]),
		.oe(mem_data_oe[1])
	);

	// ----------------------------------------
	// Response
	// ----------------------------------------
	// busy seen during strobe means the access may be void
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			busy_seen_r <= 1'b0;
		else if (state_r == DPSM_SETUP)
			busy_seen_r <= 1'b0;
		else if (state_r == DPSM_STROBE && !busy_n)
			busy_seen_r <= 1'b1;
	end

	// Read data sampled at end of strobe, before pins release
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			rsp_busy_hit <= 1'b0;
		end else begin
			rsp_valid <= (state_r == DPSM_DONE);
			if (state_r == DPSM_STROBE && cnt_r <= 4'h1 && !is_wr)
				// flag state is bit 0: 0 means ours
				rsp_rdata <= is_sem ? {{(DATA_W-1){1'b0}}, mem_data_i[0]}
					: mem_data_i;
			if (state_r == DPSM_DONE)
				rsp_busy_hit <= busy_seen_r || !busy_n;
		end
	end

	// interrupt pin, registered, for the user
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			mbox_pending <= 1'b0;
		else
			mbox_pending <= !int_n;
	end
endmodule
`default_nettype wire

/* verilog/dpsm_pkg.sv */
// Constants for the host-side port controller of a dual-port SRAM.
// Assumes a single 100 MHz system clock and one port of the memory.
package dpsm_pkg;
	// ----------------------------------------
	// Widths and mailbox locations
	// ----------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 18;
	localparam logic [15:0] MBOX_OWN_32K = 16'h7fff;
	localparam logic [15:0] MBOX_PEER_32K = 16'h7ffe;
	localparam logic [15:0] MBOX_OWN_64K = 16'hffff;
	localparam logic [15:0] MBOX_PEER_64K = 16'hfffe;
	localparam logic [15:0] ADDR_MASK_32K = 16'h7fff;
	localparam logic [15:0] ADDR_MASK_64K = 16'hffff;
	// ----------------------------------------
	// Timing, in ns and derived cycles
	// ----------------------------------------
	localparam int CLK_NS = 10;
	localparam int ACCESS_NS = 25;
	localparam int SETUP_NS = 10;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC);
	localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
	// ----------------------------------------
	// Command encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		DPSM_CMD_RAM_RD = 3'h0,
		DPSM_CMD_RAM_WR = 3'h1,
		DPSM_CMD_SEM_RD = 3'h2,
		DPSM_CMD_SEM_WR = 3'h3,
		DPSM_CMD_MBOX_SET = 3'h4,
		DPSM_CMD_MBOX_CLR = 3'h5
	} dpsm_cmd_t;
	typedef enum logic [1:0] {
		DPSM_IDLE = 2'h0,
		DPSM_SETUP = 2'h1,
		DPSM_STROBE = 2'h2,
		DPSM_DONE = 2'h3
	} dpsm_state_t;
endpackage

/* verilog/dpsm_lane.sv */
// One byte lane of the data bus: output register and enable.
// Assumes the caller decides when the lane is driven.
`timescale 1ns/1ps
`default_nettype none
module dpsm_lane #(
	parameter int W = 9
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic load,
	input wire logic drive,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout,
	output logic oe
);
	// ----------------------------------------
	// Lane registers
	// ----------------------------------------
	// Data held for whole strobe, enable follows drive request
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			dout <= '0;
			oe <= 1'b0;
		end else begin
			if (load)
				dout <= din;
			oe <= drive;
		end
	end
endmodule
`default_nettype wire

/* tb/dpsm_sva.sv */
// Pin and handshake checker for the port controller.
// Assumes it is bound onto dpsm_host; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dpsm_sva (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic mbox_pending,
	input wire logic chip_en_n,
	input wire logic rw_n,
	input wire logic out_en_n,
	input wire logic upper_lane_en_n,
	input wire logic lower_lane_en_n,
	input wire logic flag_space_sel_n,
	input wire logic [1:0] mem_data_oe,
	input wire logic int_n
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire take = req_valid && req_ready;
	wire both_off = upper_lane_en_n && lower_lane_en_n;
	resp_lat_a: assert property (take |-> ##6 rsp_valid)
		else $error("answer not six cycles after take");
	busy_hold_a: assert property (take |=> !req_ready [*4])
		else $error("request taken during an access");
	no_mix_a: assert property (!flag_space_sel_n |-> chip_en_n || both_off)
		else $error("flag select mixed with chip enable");
	flag_rd_a: assert property (!flag_space_sel_n && !out_en_n |-> rw_n)
		else $error("flag read with strobe low");
	wr_lanes_a: assert property (!chip_en_n && !rw_n
		|-> mem_data_oe == {!upper_lane_en_n, !lower_lane_en_n})
		else $error("write lanes driven wrongly");
	rd_float_a: assert property (!out_en_n |-> mem_data_oe == 2'b00)
		else $error("host drives during read");
	strobe_len_a: assert property ($fell(rw_n) |-> !rw_n [*3] ##1 rw_n)
		else $error("write strobe not three cycles");
	idle_pins_a: assert property (req_ready |-> chip_en_n && rw_n
		&& flag_space_sel_n) else $error("pins active while idle");
	mbox_seen_a: assert property (!int_n |=> mbox_pending)
		else $error("mailbox flag not seen");
	// Main scenarios reached
	cover property (!flag_space_sel_n && !rw_n);
	cover property (!chip_en_n && !rw_n && !upper_lane_en_n);
	cover property ($fell(mbox_pending));
endmodule
bind dpsm_host dpsm_sva i_sva (.clk_sys, .resetn, .req_valid, .req_ready,
	.rsp_valid, .mbox_pending, .chip_en_n, .rw_n, .out_en_n,
	.upper_lane_en_n, .lower_lane_en_n, .flag_space_sel_n, .mem_data_oe,
	.int_n);
`default_nettype wire

/* tb/dpsm_mem_model.sv */
// Behavioural model of the memory as the left port sees it.
// Assumes the bench resolves the data bus; the peer acts through tasks.
`timescale 1ns/1ps
`default_nettype none
module dpsm_mem_model
	import dpsm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic chip_en_n,
	input wire logic rw_n,
	input wire logic out_en_n,
	input wire logic upper_lane_en_n,
	input wire logic lower_lane_en_n,
	input wire logic flag_space_sel_n,
	input wire logic busy_n,
	input wire logic [DATA_W-1:0] bus,
	output logic [DATA_W-1:0] mdat,
	output logic [1:0] mdrv,
	output logic int_n
);
	logic [DATA_W-1:0] ram [0:32767];
	// flags free: 0 free, 1 left owns, 2 peer owns
	logic [1:0] own [8] = '{default: 2'd0};
	logic [7:0] lreq = 8'h00, rreq = 8'h00;
	logic own_int = 1'b0, peer_int = 1'b0;
	wire [14:0] wa = mem_addr[14:0];
	wire [2:0] fi = mem_addr[2:0];
	wire both_off = upper_lane_en_n && lower_lane_en_n;
	wire ram_sel = !chip_en_n && flag_space_sel_n && !both_off;
	wire flag_sel = !flag_space_sel_n && (chip_en_n || both_off);
	// token hand-over; left wins a tie
	function automatic logic [1:0] settle(logic [1:0] o, logic l, logic r);
		if (o == 2'd1 && !l) o = 2'd0;
		if (o == 2'd2 && !r) o = 2'd0;
		if (o == 2'd0) o = l ? 2'd1 : (r ? 2'd2 : 2'd0);
		return o;
	endfunction
	// lanes float unless read; read drive
	always_comb begin
		mdrv = 2'b00;
		mdat = ram[wa];
		if (!out_en_n && rw_n && ram_sel)
			mdrv = {!upper_lane_en_n, !lower_lane_en_n};
		if (!out_en_n && rw_n && flag_sel) begin
			mdat = {DATA_W{own[fi] != 2'd1}};
			mdrv = 2'b11;
		end
	end
	// lane writes; mailbox set gated by busy
	always @(posedge clk_sys) begin
		if (ram_sel && !rw_n) begin
			if (!upper_lane_en_n) ram[wa][17:9] <= bus[17:9];
			if (!lower_lane_en_n) ram[wa][8:0] <= bus[8:0];
			if (wa == 15'h7fff && busy_n) peer_int <= 1'b1;
		end
		if (flag_sel && !rw_n) begin
			lreq[fi] <= !bus[0];
			own[fi] <= settle(own[fi], !bus[0], rreq[fi]);
		end
		if (ram_sel && rw_n && !out_en_n && wa == 15'h7ffe && busy_n)
			own_int <= 1'b0;
	end
	assign int_n = !own_int;
	// Peer side, called away from the clock edge
	task peer_flag(input int i, input logic v);
		rreq[i] = !v;
		own[i] = settle(own[i], lreq[i], !v);
	endtask
	task peer_mbox();
		own_int = 1'b1;
	endtask
endmodule
`default_nettype wire

/* tb/dpsm_host_test.sv */
// Self-checking bench: port controller against the memory model.
// Assumes the model's tasks stand in for the right-hand port.
`timescale 1ns/1ps
`default_nettype none
module dpsm_host_test
	import dpsm_pkg::*;
;
	logic clk_sys = 1'b0, resetn = 1'b0, req_valid = 1'b0, busy_n = 1'b1;
	dpsm_cmd_t req_cmd = DPSM_CMD_RAM_RD;
	logic [ADDR_W-1:0] req_addr = '0, mem_addr;
	logic [DATA_W-1:0] req_wdata = '0, mem_data_o, mdat, rsp_rdata, r;
	logic [DATA_W-1:0] last = '0;
	logic [1:0] req_lanes = 2'b11, mem_data_oe, mdrv;
	logic req_ready, rsp_valid, rsp_busy_hit, mbox_pending, int_n;
	logic chip_en_n, rw_n, out_en_n, flag_space_sel_n;
	logic upper_lane_en_n, lower_lane_en_n;
	int fail_count = 0, num_checks = 0;
	logic [31:0] seed = 32'd80367;
	logic [2:0] st [10] = '{3'o0, 3'o4, 3'o3, 3'o1, 3'o6, 3'o3, 3'o5,
		3'o7, 3'o0, 3'o3};
	function automatic logic [DATA_W-1:0] lmask(input logic [1:0] l);
		return {{9{l[1]}}, {9{l[0]}}};
	endfunction
	// Released lanes show the inverse of the last level, not a hold
	wire [DATA_W-1:0] hm = lmask(mem_data_oe);
	wire [DATA_W-1:0] mm = lmask(mdrv) & ~hm;
	wire [DATA_W-1:0] bus = (mem_data_o & hm) | (mdat & mm) | (~last & ~mm & ~hm);
	always @(posedge clk_sys) last <= bus;
	always #5 clk_sys = ~clk_sys;
	dpsm_host i_dut (.clk_sys, .resetn, .req_valid, .req_ready, .req_cmd,
		.req_addr, .req_wdata, .req_lanes, .rsp_valid, .rsp_rdata,
		.rsp_busy_hit, .mbox_pending, .mem_addr, .chip_en_n, .rw_n, .out_en_n,
		.upper_lane_en_n, .lower_lane_en_n, .flag_space_sel_n,
		.mem_data_i(bus), .mem_data_o, .mem_data_oe, .busy_n, .int_n);
	dpsm_mem_model i_mem (.clk_sys, .mem_addr, .chip_en_n, .rw_n, .out_en_n,
		.upper_lane_en_n, .lower_lane_en_n, .flag_space_sel_n, .busy_n, .bus,
		.mdat, .mdrv, .int_n);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One whole request: hold until taken, wait bounded for the answer
	task automatic run(input dpsm_cmd_t c, input logic [15:0] a,
		input logic [DATA_W-1:0] d, input logic [1:0] l);
		int n;
		req_cmd <= c;
		req_addr <= a;
		req_wdata <= d;
		req_lanes <= l;
		req_valid <= 1'b1;
		do @(posedge clk_sys); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rsp_valid !== 1'b1 && n < 20);
		check("answer", rsp_valid, 1'b1);
		r = rsp_rdata;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#100us;
		fail_count++;
		complete_run();
	end
	initial begin
		logic [DATA_W-1:0] d0, m;
		logic [1:0] ln;
		logic [15:0] a;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		// Full word, then a random lane overwrite, read whole and by lane
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			a = 16'(seed[13:0]);
			ln = (seed[21:20] == 2'b00) ? 2'b10 : seed[21:20];
			m = lmask(ln);
			d0 = seed[31:14];
			run(DPSM_CMD_RAM_WR, a, d0, 2'b11);
			run(DPSM_CMD_RAM_WR, a, ~d0, ln);
			run(DPSM_CMD_RAM_RD, a, '0, 2'b11);
			check("ram word", r, (d0 & ~m) | (~d0 & m));
			run(DPSM_CMD_RAM_RD, a, '0, ln);
			check("ram lane", r & m, ~d0 & m);
		end
		$display("test ram done");
		for (int f = 0; f < 8; f++) begin
			run(DPSM_CMD_SEM_RD, 16'(f), '0, 2'b00);
			check("flag free", r[0], 1'b1);
		end
		// Left and peer contend for flag 5; junk above bit 0
		foreach (st[k]) begin
			seed = lfsr(seed);
			if (st[k][2]) i_mem.peer_flag(5, st[k][1]);
			else run(DPSM_CMD_SEM_WR, 16'h0005, {seed[16:0], st[k][1]}, 2'b00);
			run(DPSM_CMD_SEM_RD, 16'h0005, '0, 2'b00);
			check("flag seq", r[0], st[k][0]);
		end
		$display("test flag done");
		run(DPSM_CMD_MBOX_SET, 16'h0000, seed[17:0], 2'b11);
		check("peer int", i_mem.peer_int, 1'b1);
		i_mem.peer_mbox();
		repeat (2) @(posedge clk_sys);
		check("pending", mbox_pending, 1'b1);
		busy_n <= 1'b0;
		run(DPSM_CMD_MBOX_CLR, 16'h0000, '0, 2'b11);
		check("busy hit", rsp_busy_hit, 1'b1);
		repeat (2) @(posedge clk_sys);
		check("held", mbox_pending, 1'b1);
		busy_n <= 1'b1;
		run(DPSM_CMD_MBOX_CLR, 16'h0000, '0, 2'b11);
		check("no busy", rsp_busy_hit, 1'b0);
		repeat (2) @(posedge clk_sys);
		check("cleared", mbox_pending, 1'b0);
		$display("test mailbox done");
		complete_run();
	end
endmodule
`default_nettype wire
